// ### hw/cida_pkg.sv
package cida_pkg;
   // host-side I/O addresses of the pointer/window pair
   localparam logic [15:0] CIDA_BASE_LOW     = 16'h002e;
   localparam logic [15:0] CIDA_BASE_HIGH    = 16'h004e;
   localparam logic [15:0] CIDA_WINDOW_OFF   = 16'h0001;
   localparam logic [7:0]  CIDA_POINTER_RST  = 8'h00;
   // unbanked indexes
   localparam logic [7:0]  CIDA_IDX_BANKSEL  = 8'h07;
   localparam logic [7:0]  CIDA_IDX_GLB_LO   = 8'h20;
   localparam logic [7:0]  CIDA_IDX_GLB_HI   = 8'h2f;
   // banked indexes
   localparam logic [7:0]  CIDA_IDX_BANKED   = 8'h30;
   localparam logic [7:0]  CIDA_IDX_ACTIVATE = 8'h30;
   localparam logic [7:0]  CIDA_IDX_IOB0H    = 8'h60;
   localparam logic [7:0]  CIDA_IDX_IOB1L    = 8'h63;
   localparam logic [7:0]  CIDA_IDX_IRQNUM   = 8'h70;
   localparam logic [7:0]  CIDA_IDX_IRQTYPE  = 8'h71;
   localparam logic [7:0]  CIDA_IDX_DMA0     = 8'h74;
   localparam logic [7:0]  CIDA_IDX_DMA1     = 8'h75;
   localparam logic [7:0]  CIDA_IDX_VEND_LO  = 8'hf0;
   localparam logic [7:0]  CIDA_IDX_VEND_HI  = 8'hfe;
   // field masks (reserved bits read zero)
   localparam logic [7:0]  CIDA_ACTIVATE_MSK = 8'h01;
   localparam logic [7:0]  CIDA_IRQNUM_MSK   = 8'h1f;
   localparam logic [7:0]  CIDA_IRQTYPE_MSK  = 8'h03;
   localparam logic [7:0]  CIDA_DMA_MSK      = 8'h07;
   localparam logic [7:0]  CIDA_DMA_NONE     = 8'h04;
   localparam logic [7:0]  CIDA_UNIMPL_VAL   = 8'h00;
   localparam logic [7:0]  CIDA_BANKSEL_RST  = 8'h00;
   localparam int          CIDA_NUM_BANKS    = 13;
   localparam logic [7:0]  CIDA_LAST_BANK    = 8'h0c;
   // per-bank storage: 16 slots of one byte per bank
   localparam int          CIDA_SLOT_W       = 4;
   localparam int          CIDA_MEM_AW       = 8;
   localparam int          CIDA_GLB_AW       = 4;
   localparam logic [3:0]  CIDA_SLOT_ACT     = 4'h0;
   localparam logic [3:0]  CIDA_SLOT_IOB     = 4'h1;
   localparam logic [3:0]  CIDA_SLOT_IRQN    = 4'h5;
   localparam logic [3:0]  CIDA_SLOT_IRQT    = 4'h6;
   localparam logic [3:0]  CIDA_SLOT_DMA0    = 4'h7;
   localparam logic [3:0]  CIDA_SLOT_DMA1    = 4'h8;
   localparam logic [3:0]  CIDA_SLOT_VEND    = 4'h9;
   localparam logic [7:0]  CIDA_VEND_SPAN    = 8'h07;
endpackage

// ### hw/cida_bank_ram.sv
`timescale 1ns/1ps
module cida_bank_ram
   import cida_pkg::*;
(
   // clocking
   input  wire logic                   clk,
   input  wire logic                   ce,
   // write side
   input  wire logic                   wrEn,
   input  wire logic [CIDA_MEM_AW-1:0] wrAddr,
   input  wire logic [7:0]             wrData,
   // read side, data one cycle after address
   input  wire logic [CIDA_MEM_AW-1:0] rdAddr,
   output logic      [7:0]             rdData
);
   logic [7:0] mem [0:(1<<CIDA_MEM_AW)-1];

   // no reset: contents are defined by the shadow valid bits upstream
   always_ff @(posedge clk) begin
      if (ce) begin
         if (wrEn) begin
            mem[wrAddr] <= wrData;
         end
         rdData <= mem[rdAddr];
      end
   end
endmodule // cida_bank_ram

// ### hw/cida_config_access.sv
`timescale 1ns/1ps
// How it works
// - strap picks pointer/window pair at 2Eh/2Fh or 4Eh/4Fh.
// - eight-bit pointer register at base plus zero, read and write.
// - pointer reads back last written value, 00h after reset.
// - window port stores nothing; forwards to register pointed at.
// - pointer 30h and above reaches selected bank's register.
// - registers below 30h are one shared unbanked copy.
// - thirteen separate per-device register banks.
// - bank numbers 00h to 0Ch, one per functional block.
// - writes to nonexistent registers change nothing.
// - unimplemented reads give 00h; 74h and 75h give 04h.
// - accesses accepted right after reset, no unlock.
// - only eight-bit I/O reads and writes handled.
// - of banked registers only activate bits driven out to blocks, on devEnable; I/O base, IRQ and DMA settings stay internal.
// - bank number register at index 07h; other values reserved.
// - activate register at 30h, bit 0 enables the device.
// - reserved bits read as zero.
module cida_config_access
   import cida_pkg::*;
(
   // clocking
   input  wire logic                      clk,
   input  wire logic                      rst,
   input  wire logic                      ce,
   // strap pin
   input  wire logic                      baseSelectStrap,
   // internal bus from the bridge
   input  wire logic                      ioWrite,
   input  wire logic                      ioRead,
   input  wire logic [15:0]               ioAddr,
   input  wire logic [7:0]                ioWrData,
   output logic      [7:0]                ioRdData,
   output logic                           ioRdValid,
   output logic                           ioHit,
   // per-block controls
   output logic      [CIDA_NUM_BANKS-1:0] devEnable,
   output logic      [7:0]                globalCfg [16],
   output logic      [7:0]                bankSelectNumber
);
   logic       strapMeta_q, strapSync_q, baseHigh_q, baseHigh_d;
   logic [7:0] pointer_q, pointer_d, bankSel_q, bankSel_d;
   logic [7:0] glb_q [16];
   logic [7:0] glb_d [16];
   logic [CIDA_NUM_BANKS-1:0] act_q, act_d;
   logic [7:0] rdData_q, rdData_d, rdFix_q, rdFix_d;
   logic       rdPend_q, rdPend_d, rdFromRam_q, rdFromRam_d;
   logic [15:0] base;
   logic       hitPtr, hitWin, bankOk, inBank;
   logic [3:0] slot;
   logic [7:0] slotMsk, ramData;
   logic       ramWr;
   logic [CIDA_MEM_AW-1:0] ramAddr;
   // shadow valid bits: ram slots read 00h (or 04h) until first written
   logic [CIDA_NUM_BANKS*16-1:0] slotVal_q, slotVal_d;

   // strap sync before use
   always_ff @(posedge clk) begin
      if (ce) begin
         strapMeta_q <= baseSelectStrap;
         strapSync_q <= strapMeta_q;
      end
   end

   always_comb begin
      baseHigh_d = baseHigh_q;
      if (rst) begin
         baseHigh_d = strapSync_q;
      end
   end
   always_ff @(posedge clk) begin
      if (ce) begin
         baseHigh_q <= baseHigh_d;
      end
   end

   assign base   = baseHigh_q ? CIDA_BASE_HIGH : CIDA_BASE_LOW;
   assign hitPtr = (ioAddr == base);
   assign hitWin = (ioAddr == (base + CIDA_WINDOW_OFF));
   assign ioHit  = (hitPtr || hitWin) && !rst;
   assign bankOk = (bankSel_q <= CIDA_LAST_BANK);
   assign inBank = (pointer_q >= CIDA_IDX_BANKED) && bankOk;

   // map banked index to storage slot and field mask
   always_comb begin
      slot    = CIDA_SLOT_ACT;
      slotMsk = 8'h00;
      if (pointer_q == CIDA_IDX_ACTIVATE) begin
         slotMsk = CIDA_ACTIVATE_MSK;
      end else if (pointer_q >= CIDA_IDX_IOB0H && pointer_q <= CIDA_IDX_IOB1L) begin
         slot    = CIDA_SLOT_IOB + pointer_q[3:0];
         slotMsk = 8'hff;
      end else if (pointer_q == CIDA_IDX_IRQNUM) begin
         slot    = CIDA_SLOT_IRQN;
         slotMsk = CIDA_IRQNUM_MSK;
      end else if (pointer_q == CIDA_IDX_IRQTYPE) begin
         slot    = CIDA_SLOT_IRQT;
         slotMsk = CIDA_IRQTYPE_MSK;
      end else if (pointer_q == CIDA_IDX_DMA0) begin
         slot    = CIDA_SLOT_DMA0;
         slotMsk = CIDA_DMA_MSK;
      end else if (pointer_q == CIDA_IDX_DMA1) begin
         slot    = CIDA_SLOT_DMA1;
         slotMsk = CIDA_DMA_MSK;
      end else if (pointer_q >= CIDA_IDX_VEND_LO
                   && pointer_q <= CIDA_IDX_VEND_LO + CIDA_VEND_SPAN) begin
         slot    = CIDA_SLOT_VEND + pointer_q[3:0];
         slotMsk = 8'hff;
      end
   end

   assign ramAddr = {bankSel_q[3:0], slot};
   assign ramWr   = ce && !rst && ioWrite && hitWin && inBank && (slotMsk != 8'h00)
                    && (pointer_q != CIDA_IDX_ACTIVATE);

   cida_bank_ram uBankRam (
      .clk    (clk),
      .ce     (ce),
      .wrEn   (ramWr),
      .wrAddr (ramAddr),
      .wrData (ioWrData & slotMsk),
      .rdAddr (ramAddr),
      .rdData (ramData)
   );

   always_comb begin
      pointer_d   = pointer_q;
      bankSel_d   = bankSel_q;
      glb_d       = glb_q;
      act_d       = act_q;
      slotVal_d   = slotVal_q;
      rdPend_d    = 1'b0;
      rdFromRam_d = 1'b0;
      rdFix_d     = CIDA_UNIMPL_VAL;
      rdData_d    = rdData_q;
      if (rst) begin
         pointer_d = CIDA_POINTER_RST;
         bankSel_d = CIDA_BANKSEL_RST;
         act_d     = '0;
         slotVal_d = '0;
         for (int i = 0; i < 16; i++) begin
            glb_d[i] = 8'h00;
         end
      end else begin
         if (ioWrite && hitPtr) begin
            pointer_d = ioWrData;
         end else if (ioWrite && hitWin) begin
            if (pointer_q == CIDA_IDX_BANKSEL) begin
               bankSel_d = ioWrData;
            end else if (pointer_q >= CIDA_IDX_GLB_LO && pointer_q <= CIDA_IDX_GLB_HI) begin
               glb_d[pointer_q[3:0]] = ioWrData;
            end else if (inBank && pointer_q == CIDA_IDX_ACTIVATE) begin
               act_d[bankSel_q[3:0]] = ioWrData[0];
            end else if (ramWr) begin
               slotVal_d[ramAddr] = 1'b1;
            end
         end
         if (ioRead && hitPtr) begin
            rdPend_d = 1'b1;
            rdFix_d  = pointer_q;
         end else if (ioRead && hitWin) begin
            rdPend_d = 1'b1;
            if (pointer_q == CIDA_IDX_BANKSEL) begin
               rdFix_d = bankSel_q;
            end else if (pointer_q >= CIDA_IDX_GLB_LO && pointer_q <= CIDA_IDX_GLB_HI) begin
               rdFix_d = glb_q[pointer_q[3:0]];
            end else if (inBank && pointer_q == CIDA_IDX_ACTIVATE) begin
               rdFix_d = {7'h00, act_q[bankSel_q[3:0]]};
            end else if (inBank && slotMsk != 8'h00 && slotVal_q[ramAddr]) begin
               rdFromRam_d = 1'b1;
            end else if (pointer_q == CIDA_IDX_DMA0 || pointer_q == CIDA_IDX_DMA1) begin
               rdFix_d = CIDA_DMA_NONE;
            end else begin
               rdFix_d = CIDA_UNIMPL_VAL;
            end
         end
         if (rdPend_q) begin
            rdData_d = rdFromRam_q ? ramData : rdFix_q;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (ce) begin
         pointer_q   <= pointer_d;
         bankSel_q   <= bankSel_d;
         glb_q       <= glb_d;
         act_q       <= act_d;
         slotVal_q   <= slotVal_d;
         rdPend_q    <= rdPend_d;
         rdFromRam_q <= rdFromRam_d;
         rdFix_q     <= rdFix_d;
         rdData_q    <= rdData_d;
         ioRdValid   <= rdPend_q && !rst;
      end
      if (rst) begin
         ioRdValid <= 1'b0;
         rdPend_q  <= 1'b0;
         rdData_q  <= 8'h00;
      end
   end

   assign ioRdData = rdData_q;
   assign devEnable        = act_q;
   assign globalCfg        = glb_q;
   assign bankSelectNumber = bankSel_q;
endmodule // cida_config_access

// ### dv/cida_config_access_assertions.sv
`timescale 1ns/1ps
module cida_config_access_checker
   import cida_pkg::*;
(
   // clocking
   input wire logic                      clk,
   input wire logic                      rst,
   input wire logic                      ce,
   // watched ports
   input wire logic                      baseSelectStrap,
   input wire logic                      ioWrite,
   input wire logic                      ioRead,
   input wire logic [15:0]               ioAddr,
   input wire logic [7:0]                ioWrData,
   input wire logic [7:0]                ioRdData,
   input wire logic                      ioRdValid,
   input wire logic                      ioHit,
   input wire logic [CIDA_NUM_BANKS-1:0] devEnable,
   input wire logic [7:0]                bankSelectNumber
);
   logic        strapQ;
   logic [7:0]  ptrQ;
   logic [15:0] baseW;
   logic        winWr;
   assign baseW = strapQ ? CIDA_BASE_HIGH : CIDA_BASE_LOW;
   // frozen cycles take nothing, so the shadow must skip them too
   assign winWr = ce && ioWrite && ioHit && ioAddr[0];
   // shadow of strap and pointer to predict the window target
   always_ff @(posedge clk) begin
      strapQ <= rst ? baseSelectStrap : strapQ;
      ptrQ   <= rst ? 8'h00 : (ce && ioWrite && ioHit && !ioAddr[0]) ? ioWrData : ptrQ;
   end
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   rd_latency_a: assert property (ce && ioRead && ioHit |-> ##2 ioRdValid)
      else $error("read answer missing");
   rd_cause_a: assert property (ioRdValid |-> $past(ioRead && ioHit, 2))
      else $error("read answer without request");
   hit_match_a: assert property (ioAddr == baseW |-> ioHit)
      else $error("pointer address missed");
   hit_other_a: assert property ((ioAddr | 16'h0001) != (baseW | 16'h0001) |-> !ioHit)
      else $error("foreign address hit");
   ptr_read_a: assert property (ce && ioRead && ioHit && !ioAddr[0]
                                |-> ##2 ioRdData == $past(ptrQ, 2))
      else $error("pointer read mismatch");
   bank_write_a: assert property (winWr && ptrQ == CIDA_IDX_BANKSEL |=> bankSelectNumber == $past(ioWrData))
      else $error("bank select not written");
   bank_hold_a: assert property (!(winWr && ptrQ == CIDA_IDX_BANKSEL) |=> $stable(bankSelectNumber))
      else $error("bank select changed");
   en_hold_a: assert property (!(winWr && ptrQ == CIDA_IDX_ACTIVATE) |=> $stable(devEnable))
      else $error("enable changed");
   cover property (ioRdValid && ioRdData == CIDA_DMA_NONE);
   cover property (winWr && ptrQ == CIDA_IDX_BANKSEL);
   cover property (ioWrite && !ioHit);
endmodule // cida_config_access_checker
bind cida_config_access cida_config_access_checker cida_config_access_checker_i (.clk, .rst, .ce,
   .baseSelectStrap, .ioWrite, .ioRead, .ioAddr, .ioWrData, .ioRdData, .ioRdValid, .ioHit,
   .devEnable, .bankSelectNumber);

// ### dv/cida_lpc_host.sv
`timescale 1ns/1ps
module cida_lpc_host (
   // clocking
   input  wire logic        clk,
   // request side
   output logic             ioWrite,
   output logic             ioRead,
   output logic [15:0]      ioAddr,
   output logic [7:0]       ioWrData,
   // answer side
   input  wire logic [7:0]  ioRdData,
   input  wire logic        ioRdValid
);
   initial ioWrite = 1'b0;
   initial ioRead = 1'b0;
   initial ioAddr = 16'hffff;
   initial ioWrData = 8'hff;
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      @(posedge clk) #1;
      ioWrite = 1'b1;
      ioAddr = a;
      ioWrData = d;
      @(posedge clk) #1;
      ioWrite = 1'b0;
      // released lines never keep the old value
      ioAddr = ~a;
      ioWrData = ~d;
   endtask
   task automatic rd(input logic [15:0] a, output logic [7:0] d, output logic ok);
      @(posedge clk) #1;
      ioRead = 1'b1;
      ioAddr = a;
      @(posedge clk) #1;
      ioRead = 1'b0;
      ioAddr = ~a;
      ok = 1'b0;
      d = 8'h00;
      for (int i = 0; i < 6 && !ok; i++) begin
         if (ioRdValid === 1'b1) begin
            ok = 1'b1;
            d = ioRdData;
         end else @(posedge clk) #1;
      end
   endtask
endmodule // cida_lpc_host

// ### dv/cida_config_access_tb.sv
`timescale 1ns/1ps
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin num_errors++; \
   $display("wrong value at %0t: got %h expected %h", $time, (a), (e)); end end
module cida_config_access_tb
   import cida_pkg::*;
;
   logic                      clk = 1'b0;
   logic                      rst, ce, baseSelectStrap, ioWrite, ioRead, ioRdValid, ioHit;
   logic [15:0]               ioAddr, base;
   logic [7:0]                ioWrData, ioRdData, bankSelectNumber, v;
   logic [CIDA_NUM_BANKS-1:0] devEnable;
   logic [7:0]                globalCfg [16];
   int                        num_errors = 0;
   int                        comparisons = 0;
   cida_config_access cida_config_access_i (.clk, .rst, .ce, .baseSelectStrap, .ioWrite,
      .ioRead, .ioAddr, .ioWrData, .ioRdData, .ioRdValid, .ioHit, .devEnable, .globalCfg,
      .bankSelectNumber);
   cida_lpc_host cida_lpc_host_i (.clk, .ioWrite, .ioRead, .ioAddr, .ioWrData, .ioRdData,
      .ioRdValid);
   always #5 clk = ~clk;
   task automatic conclude();
      $display("comparisons %0d mismatches %0d", comparisons, num_errors);
      if (num_errors == 0 && comparisons > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   task automatic getRaw(input logic [15:0] a, output logic [7:0] d);
      logic ok;
      cida_lpc_host_i.rd(a, d, ok);
      if (ok !== 1'b1) begin
         num_errors++;
         conclude();
      end
   endtask
   task automatic setReg(input logic [7:0] idx, input logic [7:0] d);
      cida_lpc_host_i.wr(base, idx);
      cida_lpc_host_i.wr(base + 16'h0001, d);
   endtask
   task automatic getReg(input logic [7:0] idx, output logic [7:0] d);
      cida_lpc_host_i.wr(base, idx);
      getRaw(base + 16'h0001, d);
   endtask
   task automatic doReset(input logic s);
      baseSelectStrap = s;
      rst = 1'b1;
      repeat (12) @(posedge clk);
      #1 rst = 1'b0;
      base = s ? CIDA_BASE_HIGH : CIDA_BASE_LOW;
   endtask
   initial begin
      ce = 1'b1;
      doReset(1'b0);
      getRaw(base, v);
      `CHK(v, CIDA_POINTER_RST)
      getReg(CIDA_IDX_DMA0, v);
      `CHK(v, CIDA_DMA_NONE)
      getReg(CIDA_IDX_DMA1, v);
      `CHK(v, CIDA_DMA_NONE)
      getRaw(base, v);
      `CHK(v, CIDA_IDX_DMA1)
      setReg(8'h40, 8'h5a);
      getReg(8'h40, v);
      `CHK(v, CIDA_UNIMPL_VAL)
      $display("test reset and unimplemented done");
      for (int b = 0; b < CIDA_NUM_BANKS; b++) begin
         setReg(CIDA_IDX_BANKSEL, 8'(b));
         setReg(CIDA_IDX_ACTIVATE, {7'h7f, 1'(b)});
         setReg(CIDA_IDX_IOB0H, 8'(b) + 8'ha0);
      end
      for (int b = 0; b < CIDA_NUM_BANKS; b++) begin
         setReg(CIDA_IDX_BANKSEL, 8'(b));
         getReg(CIDA_IDX_ACTIVATE, v);
         `CHK(v, {7'h00, 1'(b)})
         `CHK(devEnable[b], 1'(b))
         getReg(CIDA_IDX_IOB0H, v);
         `CHK(v, 8'(b) + 8'ha0)
      end
      getReg(CIDA_IDX_BANKSEL, v);
      `CHK(v, CIDA_LAST_BANK)
      $display("test banks done");
      setReg(CIDA_IDX_GLB_LO, 8'h3c);
      setReg(CIDA_IDX_BANKSEL, 8'h03);
      getReg(CIDA_IDX_GLB_LO, v);
      `CHK(v, 8'h3c)
      `CHK(globalCfg[0], 8'h3c)
      // a pointer write while the clock enable is low must be lost
      @(posedge clk) #1 ce = 1'b0;
      cida_lpc_host_i.wr(base, 8'h33);
      ce = 1'b1;
      getRaw(base, v);
      `CHK(v, CIDA_IDX_GLB_LO)
      // reserved bank number reaches nothing
      setReg(CIDA_IDX_BANKSEL, 8'h0d);
      getReg(CIDA_IDX_IOB0H, v);
      `CHK(v, CIDA_UNIMPL_VAL)
      baseSelectStrap = 1'b1;
      cida_lpc_host_i.wr(CIDA_BASE_HIGH, 8'h11);
      getRaw(base, v);
      `CHK(v, CIDA_IDX_IOB0H)
      doReset(1'b1);
      cida_lpc_host_i.wr(base, 8'h22);
      getRaw(base, v);
      `CHK(v, 8'h22)
      $display("test globals and strap done");
      conclude();
   end
endmodule // cida_config_access_tb
